// *** ccs_changeover.sv ***
// Settle counter and glitch-free clock select handover.
`timescale 1ns/10ps
`default_nettype none
module ccs_changeover (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Controller side
  ccs_chg_if.unit chg
);
  logic [3:0] cnt_q;
  logic busy_q;
  logic drop_q;
  logic pick_q;
  logic [2:0] sel_q;
  logic gate_q;
  logic done_q;
  wire settle_end = busy_q && chg.new_tick && (cnt_q == ccs_pkg::SETTLE_LAST);

  assign chg.sel = sel_q;
  assign chg.gate = gate_q;
  assign chg.done = done_q;

  // Outside a forced select, the old clock is released only at its own tick, and the new one is picked up only
  // at its own tick, so neither source can leave a runt pulse on the system clock.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      drop_q <= 1'b0;
      pick_q <= 1'b0;
      sel_q <= ccs_pkg::SRC_FRC;
      gate_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (chg.force_sel) begin
        sel_q <= chg.forced_src;
        gate_q <= 1'b1;
        busy_q <= 1'b0;
        drop_q <= 1'b0;
        pick_q <= 1'b0;
      end else if (chg.start) begin
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
      end else if (settle_end) begin
        busy_q <= 1'b0;
        drop_q <= 1'b1;
      end else if (busy_q && chg.new_tick) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (drop_q && chg.old_tick) begin
        gate_q <= 1'b0;
        drop_q <= 1'b0;
        pick_q <= 1'b1;
      end else if (pick_q && chg.new_tick) begin
        sel_q <= chg.new_src;
        gate_q <= 1'b1;
        pick_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** ccs_chg_if.sv ***
// Link between the switch controller and the glitch-free changeover unit.
`timescale 1ns/10ps
`default_nettype none
interface ccs_chg_if;
  logic start;
  logic force_sel;
  logic [2:0] forced_src;
  logic [2:0] new_src;
  logic new_tick;
  logic old_tick;
  logic done;
  logic [2:0] sel;
  logic gate;

  modport ctl (
    output start, force_sel, forced_src, new_src, new_tick, old_tick,
    input done, sel, gate
  );
  modport unit (
    input start, force_sel, forced_src, new_src, new_tick, old_tick,
    output done, sel, gate
  );
endinterface
`default_nettype wire

// *** ccs_osc_model.sv ***
// Behavioural oscillator sources with ticks, crystal start-up timer and PLL lock.
`timescale 1ns/10ps
`default_nettype none
module ccs_osc_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Enables as {pll, low_power_rc_osc, secondary, primary, fast}
  input wire logic [4:0] osc_en,
  input wire logic slow,
  // Source outputs
  output logic [7:0] src_tick,
  output logic crystal_startup_timer_done,
  output logic pll_lock_in
);
  logic [3:0] ost_q;
  logic [3:0] pll_q;
  logic ph_q;
  logic [7:0] run;
  // A source that is off never ticks, so a sequencer that skips enabling it hangs.
  assign run = {osc_en[0], osc_en[0], osc_en[3], osc_en[2], osc_en[1], osc_en[1],
                osc_en[0], osc_en[0]};
  assign src_tick = (slow && ph_q) ? 8'h00 : run;
  assign crystal_startup_timer_done = ost_q >= (slow ? 4'hC : 4'h4);
  assign pll_lock_in = pll_q >= (slow ? 4'hA : 4'h3);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ost_q <= 4'h0;
      pll_q <= 4'h0;
      ph_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      ost_q <= !osc_en[1] ? 4'h0 : (ost_q == 4'hF ? ost_q : ost_q + 4'h1);
      pll_q <= !osc_en[4] ? 4'h0 : (pll_q == 4'hF ? pll_q : pll_q + 4'h1);
    end
  end
endmodule
`default_nettype wire

// *** ccs_pkg.sv ***
// Constants, encodings and helper functions for the clock switch and power mode controller.
package ccs_pkg;
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
  localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
  localparam logic [2:0] SRC_FRC_DIVN = 3'h7;

  // Field positions within the two control bytes.
  localparam int HI_NEW_SRC_LSB = 0;
  localparam int LO_SWITCH_BIT = 0;
  localparam int LO_SEC_EN_BIT = 1;
  localparam int LO_CF_BIT = 3;

  localparam logic [3:0] SETTLE_CYCLES = 4'hA;
  localparam logic [3:0] SETTLE_LAST = 4'h9;

  typedef enum {SW_IDLE, SW_OST, SW_PLL, SW_SETTLE} ccs_sw_state_e;
  typedef enum {PM_RUN, PM_ENTER, PM_SLEEP, PM_IDLE} ccs_pm_state_e;

  // Oscillators a source needs, as {low_power_rc_osc, secondary, primary, fast rc}.
  function automatic logic [3:0] ccs_osc_need(input logic [2:0] src);
    logic [3:0] n;
    n = 4'h0;
    if (src == SRC_PRI || src == SRC_PRI_PLL) begin
      n = 4'h2;
    end else if (src == SRC_SEC) begin
      n = 4'h4;
    end else if (src == SRC_LOW_POWER_RC_OSC) begin
      n = 4'h8;
    end else begin
      n = 4'h1;
    end
    return n;
  endfunction

  function automatic logic ccs_uses_pll(input logic [2:0] src);
    return (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
  endfunction
endpackage

// *** ccs_top.sv ***
// Clock switch sequencer, fail-safe fallback and Sleep/Idle power mode control.
`timescale 1ns/10ps
`default_nettype none
module ccs_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration straps
  input wire logic cfg_switch_enable,
  input wire logic cfg_failsafe_enable,
  input wire logic [2:0] initial_source_config,
  input wire logic cfg_watchdog_enable,
  input wire logic cfg_primary_is_crystal,
  // Software control byte writes
  input wire logic sw_unlock,
  input wire logic sw_wr_high,
  input wire logic sw_wr_low,
  input wire logic [7:0] sw_wdata,
  // Software visible status
  output logic [2:0] current_source_sel,
  output logic [2:0] requested_source_sel,
  output logic switch_request,
  output logic pll_locked_flag,
  output logic clock_fail_flag,
  output logic secondary_osc_enable,
  // Oscillator sources
  input wire logic [7:0] src_tick,
  input wire logic crystal_startup_timer_done,
  input wire logic pll_lock_in,
  input wire logic osc_fail,
  output logic fast_internal_osc_en,
  output logic primary_osc_en,
  output logic secondary_osc_en,
  output logic low_power_rc_osc_en,
  output logic pll_en,
  // System clock mux
  output logic [2:0] sys_clk_sel,
  output logic sys_clk_run,
  // Processor core
  input wire logic power_save_sleep,
  input wire logic power_save_idle,
  input wire logic irq_wake,
  input wire logic watchdog_timeout,
  output logic cpu_clk_enable,
  output logic periph_clk_enable,
  output logic clock_fail_trap,
  output logic watchdog_clear,
  output logic cpu_resume,
  output logic in_sleep,
  output logic in_idle
);
  ccs_chg_if chg ();

  ccs_pkg::ccs_sw_state_e sw_q;
  ccs_pkg::ccs_pm_state_e pm_q;
  logic [2:0] cur_q;
  logic [2:0] req_q;
  logic swreq_q;
  logic lock_q;
  logic cf_q;
  logic sec_en_q;
  logic arm_q;
  logic init_q;
  logic ost_need_q;
  logic sleep_q;
  logic idle_q;
  logic pend_q;
  logic trap_q;
  logic wdt_clr_q;
  logic resume_q;

  ccs_changeover u_chg (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .chg(chg)
  );

  // Write acceptance: one unlock arms exactly one following byte write.
  wire wr_any = sw_wr_high || sw_wr_low;
  wire wr_hi_ok = sw_wr_high && arm_q;
  wire wr_lo_ok = sw_wr_low && arm_q;
  wire [2:0] wr_new_src = sw_wdata[ccs_pkg::HI_NEW_SRC_LSB +: 3];
  wire wr_switch = sw_wdata[ccs_pkg::LO_SWITCH_BIT];
  wire wr_sec_en = sw_wdata[ccs_pkg::LO_SEC_EN_BIT];
  wire wr_cf_clr = wr_lo_ok && !sw_wdata[ccs_pkg::LO_CF_BIT];

  // Source decoding.
  wire [3:0] need_cur = ccs_pkg::ccs_osc_need(cur_q);
  wire [3:0] need_req = ccs_pkg::ccs_osc_need(req_q);
  wire switching = (sw_q != ccs_pkg::SW_IDLE);
  wire asleep = sleep_q;
  wire sw_go = (sw_q == ccs_pkg::SW_IDLE) && swreq_q && cfg_switch_enable && init_q && !asleep;
  wire sw_redundant = sw_go && (req_q == cur_q);
  wire sw_valid = sw_go && (req_q != cur_q);
  wire ost_need = cfg_primary_is_crystal && need_req[1] && !need_cur[1];
  wire ost_ok = !ost_need_q || crystal_startup_timer_done;
  wire pll_ok = !ccs_pkg::ccs_uses_pll(req_q) || lock_q;
  wire chg_start = (sw_q == ccs_pkg::SW_PLL) && pll_ok;
  wire chg_commit = (sw_q == ccs_pkg::SW_SETTLE) && chg.done;
  wire monitor_on = cfg_failsafe_enable && !asleep;
  wire fail_evt = monitor_on && osc_fail && init_q;
  wire [2:0] fallback_src = ccs_pkg::ccs_uses_pll(cur_q) ? ccs_pkg::SRC_FRC_PLL
                                                         : ccs_pkg::SRC_FRC;

  // Power mode wake and entry decoding.
  wire pm_cmd = power_save_sleep || power_save_idle;
  wire wake_evt = irq_wake || watchdog_timeout || pend_q;
  wire pm_wake = ((pm_q == ccs_pkg::PM_SLEEP) || (pm_q == ccs_pkg::PM_IDLE)) && wake_evt;

  assign chg.start = chg_start;
  assign chg.force_sel = fail_evt || !init_q;
  assign chg.forced_src = init_q ? fallback_src : initial_source_config;
  assign chg.new_src = req_q;
  assign chg.new_tick = src_tick[req_q];
  assign chg.old_tick = src_tick[cur_q];

  // Oscillator enables: the old source drops as soon as current moves off it, unless sec_en_q, the watchdog or the monitor keeps it on.
  wire need_frc = need_cur[0] || (switching && need_req[0]);
  wire need_pri = need_cur[1] || (switching && need_req[1]);
  wire need_sec = need_cur[2] || (switching && need_req[2]);
  wire need_lp = need_cur[3] || (switching && need_req[3]);
  wire need_pll = ccs_pkg::ccs_uses_pll(cur_q) || (switching && ccs_pkg::ccs_uses_pll(req_q));

  assign fast_internal_osc_en = !asleep && need_frc;
  assign primary_osc_en = !asleep && need_pri;
  assign secondary_osc_en = sec_en_q || (!asleep && need_sec);
  assign low_power_rc_osc_en = cfg_watchdog_enable || monitor_on || (!asleep && need_lp);
  assign pll_en = !asleep && need_pll;

  assign current_source_sel = cur_q;
  assign requested_source_sel = req_q;
  assign switch_request = swreq_q;
  assign pll_locked_flag = lock_q;
  assign clock_fail_flag = cf_q;
  assign secondary_osc_enable = sec_en_q;
  assign sys_clk_sel = chg.sel;
  assign sys_clk_run = chg.gate && !sleep_q;
  // The processor never stalls for a clock switch; only the power modes stop it.
  assign cpu_clk_enable = !sleep_q && !idle_q;
  assign periph_clk_enable = !sleep_q;
  assign clock_fail_trap = trap_q;
  assign watchdog_clear = wdt_clr_q;
  assign cpu_resume = resume_q;
  assign in_sleep = sleep_q;
  assign in_idle = idle_q;

  // The initial source strap is caught on the first clock after reset release, never by the reset itself.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
      if (sw_unlock) begin
        arm_q <= 1'b1;
      end else if (wr_any) begin
        arm_q <= 1'b0;
      end
    end
  end

  // Current and requested source selections.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= ccs_pkg::SRC_FRC;
      req_q <= ccs_pkg::SRC_FRC;
    end else if (!init_q) begin
      cur_q <= initial_source_config;
      req_q <= initial_source_config;
    end else if (fail_evt) begin
      cur_q <= fallback_src;
      req_q <= fallback_src;
    end else begin
      if (chg_commit) begin
        cur_q <= req_q;
      end
      // A new source written mid-switch would retarget a half-done handover, so it is dropped.
      if (wr_hi_ok && !switching) begin
        req_q <= wr_new_src;
      end
    end
  end

  // Switch request, secondary enable and status flags.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      swreq_q <= 1'b0;
      sec_en_q <= 1'b0;
      lock_q <= 1'b0;
      cf_q <= 1'b0;
    end else begin
      if (!cfg_switch_enable || fail_evt || sw_redundant || chg_commit) begin
        swreq_q <= 1'b0;
      end else if (wr_lo_ok && wr_switch) begin
        swreq_q <= 1'b1;
      end
      if (wr_lo_ok) begin
        sec_en_q <= wr_sec_en;
      end
      if (sw_valid) begin
        lock_q <= 1'b0;
      end else if (pll_en && pll_lock_in) begin
        lock_q <= 1'b1;
      end else if (!pll_en) begin
        lock_q <= 1'b0;
      end
      if (fail_evt) begin
        cf_q <= 1'b1;
      end else if (sw_valid || wr_cf_clr) begin
        cf_q <= 1'b0;
      end
    end
  end

  // Switch sequencer.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_q <= ccs_pkg::SW_IDLE;
      ost_need_q <= 1'b0;
    end else if (fail_evt) begin
      sw_q <= ccs_pkg::SW_IDLE;
    end else begin
      case (sw_q)
        ccs_pkg::SW_IDLE: begin
          if (sw_valid) begin
            ost_need_q <= ost_need;
            sw_q <= ccs_pkg::SW_OST;
          end
        end
        ccs_pkg::SW_OST: begin
          if (ost_ok) begin
            sw_q <= ccs_pkg::SW_PLL;
          end
        end
        ccs_pkg::SW_PLL: begin
          if (pll_ok) begin
            sw_q <= ccs_pkg::SW_SETTLE;
          end
        end
        ccs_pkg::SW_SETTLE: begin
          if (chg.done) begin
            sw_q <= ccs_pkg::SW_IDLE;
          end
        end
        default: begin
          sw_q <= ccs_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // Power mode sequencer. Current source is left alone, so Sleep wakes on it again.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_q <= ccs_pkg::PM_RUN;
      sleep_q <= 1'b0;
      idle_q <= 1'b0;
      pend_q <= 1'b0;
      wdt_clr_q <= 1'b0;
      resume_q <= 1'b0;
    end else begin
      wdt_clr_q <= 1'b0;
      resume_q <= 1'b0;
      case (pm_q)
        ccs_pkg::PM_RUN: begin
          if (pm_cmd) begin
            sleep_q <= power_save_sleep;
            idle_q <= !power_save_sleep;
            pend_q <= irq_wake;
            wdt_clr_q <= cfg_watchdog_enable;
            pm_q <= ccs_pkg::PM_ENTER;
          end
        end
        ccs_pkg::PM_ENTER: begin
          pend_q <= pend_q || irq_wake;
          pm_q <= sleep_q ? ccs_pkg::PM_SLEEP : ccs_pkg::PM_IDLE;
        end
        ccs_pkg::PM_SLEEP, ccs_pkg::PM_IDLE: begin
          if (pm_wake) begin
            sleep_q <= 1'b0;
            idle_q <= 1'b0;
            pend_q <= 1'b0;
            resume_q <= 1'b1;
            pm_q <= ccs_pkg::PM_RUN;
          end
        end
        default: begin
          pm_q <= ccs_pkg::PM_RUN;
        end
      endcase
    end
  end

  // Trap pulse to the core on a detected oscillator failure.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_q <= 1'b0;
    end else begin
      trap_q <= fail_evt;
    end
  end
endmodule
`default_nettype wire

// *** ccs_top_asserts.sv ***
// Concurrent checks on the clock switch and power mode controller ports.
`timescale 1ns/10ps
`default_nettype none
module ccs_top_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic cfg_failsafe_enable,
  input wire logic cfg_watchdog_enable,
  input wire logic [2:0] current_source_sel,
  input wire logic [2:0] requested_source_sel,
  input wire logic switch_request,
  input wire logic clock_fail_flag,
  input wire logic osc_fail,
  input wire logic low_power_rc_osc_en,
  input wire logic sys_clk_run,
  input wire logic power_save_sleep,
  input wire logic power_save_idle,
  input wire logic watchdog_timeout,
  input wire logic irq_wake,
  input wire logic cpu_clk_enable,
  input wire logic periph_clk_enable,
  input wire logic clock_fail_trap,
  input wire logic watchdog_clear,
  input wire logic cpu_resume,
  input wire logic in_sleep,
  input wire logic in_idle
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_fail_fallback: assert property (osc_fail && cfg_failsafe_enable && !in_sleep |=>
    clock_fail_trap && clock_fail_flag && current_source_sel inside {3'h0, 3'h1})
    else $error("fail-safe fallback missing");
  chk_sleep_no_monitor: assert property (in_sleep && osc_fail |=> !clock_fail_trap)
    else $error("monitor active in sleep");
  chk_sleep_clocks_off: assert property (in_sleep |->
    !sys_clk_run && !cpu_clk_enable && !periph_clk_enable)
    else $error("clocks running in sleep");
  chk_idle_clocks: assert property (in_idle |-> !cpu_clk_enable && periph_clk_enable)
    else $error("idle clock gating wrong");
  chk_wdt_entry_clear: assert property ((power_save_sleep || power_save_idle) &&
    cfg_watchdog_enable && !in_sleep && !in_idle |=> watchdog_clear)
    else $error("watchdog not cleared on entry");
  chk_low_power_rc_osc_kept_on: assert property (cfg_watchdog_enable ||
    (cfg_failsafe_enable && !in_sleep) |-> low_power_rc_osc_en)
    else $error("low power oscillator off");
  chk_wake_bound: assert property ((in_idle && $past(in_idle) || in_sleep && $past(in_sleep))
    && (irq_wake || watchdog_timeout) |-> ##[1:2] !(in_idle || in_sleep))
    else $error("no wake on event");
  chk_resume_pulse: assert property ($fell(in_idle) || $fell(in_sleep) |-> ##[0:1] cpu_resume)
    else $error("no resume after wake");
  chk_commit_source: assert property ($fell(switch_request) |->
    current_source_sel == requested_source_sel)
    else $error("request cleared without commit");
  cov_fail: cover property (clock_fail_trap);
  cov_sleep: cover property ($fell(in_sleep));
  cov_switch: cover property ($fell(switch_request));
endmodule
bind ccs_top ccs_top_asserts u_ccs_top_asserts (.*);
`default_nettype wire

// *** ccs_top_tb.sv ***
// Self-checking testbench for the clock switch and power mode controller.
`timescale 1ns/10ps
`default_nettype none
module ccs_top_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_switch_enable = 1'b1;
  logic cfg_failsafe_enable = 1'b1;
  logic cfg_watchdog_enable = 1'b1;
  logic cfg_primary_is_crystal = 1'b1;
  logic [2:0] initial_source_config = ccs_pkg::SRC_FRC;
  logic sw_unlock = 1'b0, sw_wr_high = 1'b0, sw_wr_low = 1'b0;
  logic [7:0] sw_wdata = 8'h00;
  logic osc_fail = 1'b0, power_save_sleep = 1'b0, power_save_idle = 1'b0;
  logic irq_wake = 1'b0, watchdog_timeout = 1'b0, slow = 1'b0;
  logic [7:0] src_tick;
  logic crystal_startup_timer_done, pll_lock_in, sys_clk_run, cpu_clk_enable;
  logic [2:0] current_source_sel, requested_source_sel, sys_clk_sel, cur;
  logic switch_request, pll_locked_flag, clock_fail_flag, secondary_osc_enable;
  logic fast_internal_osc_en, primary_osc_en, secondary_osc_en, low_power_rc_osc_en, pll_en;
  logic periph_clk_enable, clock_fail_trap, watchdog_clear, cpu_resume, in_sleep, in_idle;
  logic [4:0] en;
  int failures = 0, num_checks = 0, resumes = 0;
  assign en = {pll_en, low_power_rc_osc_en, secondary_osc_en, primary_osc_en,
               fast_internal_osc_en};
  ccs_top u_ccs_top (.*);
  ccs_osc_model u_ccs_osc_model (.sys_clk(sys_clk), .rst_n(rst_n), .osc_en(en), .slow(slow),
    .src_tick(src_tick), .crystal_startup_timer_done(crystal_startup_timer_done),
    .pll_lock_in(pll_lock_in));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (cpu_resume === 1'b1) begin
      resumes++;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Optional unlock, then one byte write pulse.
  task automatic wr(input logic hi, input logic [7:0] d, input logic unl);
    @(posedge sys_clk);
    sw_unlock <= unl;
    @(posedge sys_clk);
    sw_unlock <= 1'b0;
    sw_wr_high <= hi;
    sw_wr_low <= !hi;
    sw_wdata <= d;
    @(posedge sys_clk);
    sw_wr_high <= 1'b0;
    sw_wr_low <= 1'b0;
  endtask
  // Waits on the sampled level of a flag, cutting the run short once it is still high after lim cycles.
  task automatic wait_low(ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b0) begin
      @(negedge sys_clk);
      n++;
      if (n > lim) begin
        failures++;
        report_and_stop();
      end
    end
  endtask
  // Oscillator enables expected once a source is in use, as {pll, low_power_rc_osc, sec, pri, fast}.
  function automatic logic [4:0] exp_en(input logic [2:0] s);
    exp_en = {s == 3'h1 || s == 3'h3, 1'b1, s == 3'h4, s == 3'h2 || s == 3'h3,
              s == 3'h0 || s == 3'h1 || s[2:1] == 2'h3};
  endfunction
  task automatic t_switch(input logic [2:0] dst, input logic slw, input logic ksec);
    int n;
    slow <= slw;
    wr(1'b1, {5'h00, dst}, 1'b1);
    wr(1'b0, {6'h00, ksec, 1'b1}, 1'b1);
    n = 0;
    do begin
      @(negedge sys_clk);
      check(cpu_clk_enable, 1'b1);
      n++;
      if (n > 300) begin
        failures++;
        report_and_stop();
      end
    end while (switch_request === 1'b1);
    // The lock flag follows the PLL enable one cycle after the commit.
    @(negedge sys_clk);
    check(n > 12, 1'b1);
    check(current_source_sel, dst);
    check(sys_clk_sel, dst);
    check(clock_fail_flag, 1'b0);
    check(pll_locked_flag, dst == ccs_pkg::SRC_FRC_PLL || dst == ccs_pkg::SRC_PRI_PLL);
    check(secondary_osc_enable, ksec);
    check(en, exp_en(dst) | {2'h0, ksec, 2'h0});
    cur = dst;
  endtask
  task automatic t_lock_and_redundant();
    wr(1'b1, {5'h00, cur}, 1'b1);
    wr(1'b1, 8'h02, 1'b0);
    @(negedge sys_clk);
    check(requested_source_sel, cur);
    wr(1'b0, 8'h01, 1'b1);
    repeat (2) @(negedge sys_clk);
    check(switch_request, 1'b0);
    check(current_source_sel, cur);
    @(posedge sys_clk);
    cfg_switch_enable <= 1'b0;
    wr(1'b1, 8'h02, 1'b1);
    wr(1'b0, 8'h01, 1'b1);
    repeat (3) @(negedge sys_clk);
    check({switch_request, current_source_sel}, {1'b0, cur});
    @(posedge sys_clk);
    cfg_switch_enable <= 1'b1;
  endtask
  task automatic t_fail(input logic [2:0] exp_src);
    @(posedge sys_clk);
    osc_fail <= 1'b1;
    @(posedge sys_clk);
    osc_fail <= 1'b0;
    @(negedge sys_clk);
    check({clock_fail_trap, clock_fail_flag}, 2'h3);
    check(current_source_sel, exp_src);
    check(sys_clk_sel, exp_src);
    cur = exp_src;
  endtask
  task automatic t_power(input logic sleep, input logic coincide);
    int r0;
    r0 = resumes;
    @(posedge sys_clk);
    power_save_sleep <= sleep;
    power_save_idle <= !sleep;
    irq_wake <= coincide;
    @(posedge sys_clk);
    {power_save_sleep, power_save_idle, irq_wake} <= 3'h0;
    @(negedge sys_clk);
    check({in_sleep, in_idle}, {sleep, !sleep});
    check(watchdog_clear, cfg_watchdog_enable);
    check({cpu_clk_enable, periph_clk_enable}, {1'b0, !sleep});
    check({low_power_rc_osc_en, fast_internal_osc_en},
          {!sleep || cfg_watchdog_enable, !sleep});
    if (!coincide) begin
      @(posedge sys_clk);
      osc_fail <= 1'b1;
      @(posedge sys_clk);
      osc_fail <= 1'b0;
      @(negedge sys_clk);
      check({clock_fail_trap, in_sleep | in_idle}, {!sleep, 1'b1});
      @(posedge sys_clk);
      irq_wake <= sleep;
      watchdog_timeout <= !sleep;
    end
    wait_low(in_sleep, 6);
    wait_low(in_idle, 6);
    @(posedge sys_clk);
    {irq_wake, watchdog_timeout} <= 2'h0;
    repeat (2) @(negedge sys_clk);
    check(resumes - r0, 1);
    check({cpu_clk_enable, current_source_sel}, {1'b1, cur});
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    cur = ccs_pkg::SRC_FRC;
    check({switch_request, current_source_sel, sys_clk_run}, {1'b0, cur, 1'b1});
    t_lock_and_redundant();
    t_switch(ccs_pkg::SRC_PRI_PLL, 1'b1, 1'b0);
    t_fail(ccs_pkg::SRC_FRC_PLL);
    t_switch(ccs_pkg::SRC_FRC, 1'b0, 1'b0);
    t_switch(ccs_pkg::SRC_PRI, 1'b0, 1'b0);
    t_fail(ccs_pkg::SRC_FRC);
    // The secondary enable bit stays set across the next switch, so that source must stay on.
    t_switch(ccs_pkg::SRC_SEC, 1'b0, 1'b1);
    t_switch(ccs_pkg::SRC_LOW_POWER_RC_OSC, 1'b1, 1'b1);
    t_switch(ccs_pkg::SRC_FRC_PLL, 1'b0, 1'b0);
    t_switch(ccs_pkg::SRC_FRC_DIV16, 1'b0, 1'b0);
    t_switch(ccs_pkg::SRC_FRC_DIVN, 1'b0, 1'b0);
    t_switch(ccs_pkg::SRC_FRC, 1'b0, 1'b0);
    t_power(1'b1, 1'b0);
    t_power(1'b0, 1'b0);
    t_power(1'b0, 1'b1);
    // With the watchdog off, only the monitor keeps the low-power oscillator running.
    @(posedge sys_clk);
    cfg_watchdog_enable <= 1'b0;
    t_power(1'b1, 1'b0);
    t_power(1'b0, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
